// ---- hw/mtsc_regs.vh ----
// register map, field positions and reset values of the symbol codec
`ifndef MTSC_REGS_VH
`define MTSC_REGS_VH

`define MTSC_PAGE 8'h02
`define MTSC_ADDR_LOW 8'hC2
`define MTSC_ADDR_MID 8'hC3
`define MTSC_ADDR_HIGH 8'hC4
`define MTSC_ADDR_CTL 8'hC5

`define MTSC_BIT_READY 7
`define MTSC_BIT_ERROR 6
`define MTSC_BIT_ENC 5
`define MTSC_BIT_DEC 4
`define MTSC_BIT_DMA 2
`define MTSC_BIT_ENDIAN 1
`define MTSC_BIT_MODE 0

`define MTSC_RST_BYTE 8'h00
`define MTSC_FIFO_DEPTH 4
`define MTSC_ERR_FILL 8'hFF

`endif

// ---- hw/mtsc_fifo.v ----
// small synchronous fifo with registered ready and valid flags
`timescale 1ns/100ps
module mtsc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk_i,
	input wire rstn_i,
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output reg in_ready_o,
	output reg out_valid_o,
	output wire [WIDTH-1:0] out_data_o,
	input wire out_ready_i
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	reg [AW:0] count_nxt;
	wire push;
	wire pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_r[rd_ptr_r];

	always @* begin
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + {{AW{1'b0}}, 1'b1};
		else if (pop && !push)
			count_nxt = count_r - {{AW{1'b0}}, 1'b1};
	end

	always @(posedge clk_i) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_i;
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			count_r <= count_nxt;
			in_ready_o <= (count_nxt != DEPTH);
			out_valid_o <= (count_nxt != {(AW+1){1'b0}});
		end
	end
endmodule // mtsc_fifo

// ---- hw/mtsc_codec.v ----
// manchester and three-out-of-six codec with register port and dma byte streams
`timescale 1ns/100ps
`include "mtsc_regs.vh"

module mtsc_codec (
	input wire SYS_CLK_I,
	input wire RSTN_I,
	input wire [7:0] SFR_PAGE_I,
	input wire [7:0] SFR_ADDR_I,
	input wire SFR_WR_I,
	input wire SFR_RD_I,
	input wire [7:0] SFR_WDATA_I,
	output reg [7:0] SFR_RDATA_O,
	input wire DMA_IN_VALID_I,
	input wire [7:0] DMA_IN_DATA_I,
	output wire DMA_IN_READY_O,
	output reg DMA_OUT_VALID_O,
	output reg [7:0] DMA_OUT_DATA_O,
	input wire DMA_OUT_READY_I,
	output wire DEC_ERR_O
);
	localparam ST_FILL = 2'h0;
	localparam ST_CALC = 2'h1;
	localparam ST_DRAIN = 2'h2;

	reg [23:0] data_r;
	reg ready_r;
	reg error_r;
	reg enc_r;
	reg dec_r;
	reg dma_r;
	reg endian_r;
	reg mode_r;
	reg [1:0] st_r;
	reg [1:0] cnt_r;
	reg [23:0] res;
	reg res_err;
	reg [1:0] in_idx;
	reg [1:0] out_idx;
	reg [7:0] out_byte;
	reg [7:0] man_byte;
	reg man_bad;
	reg [15:0] six_nib;
	reg six_bad;
	reg [4:0] dsym;
	integer i;

	wire page_hit;
	wire ctl_wr;
	wire active;
	wire reg_done;
	wire dma_done;
	wire [1:0] n_in;
	wire [1:0] n_out;
	wire fifo_vld;
	wire [7:0] fifo_data;
	wire fifo_pop;

	function [5:0] enc6;
		input [3:0] nib;
		begin
			case (nib)
				4'h0: enc6 = 6'h16;
				4'h1: enc6 = 6'h0D;
				4'h2: enc6 = 6'h0E;
				4'h3: enc6 = 6'h0B;
				4'h4: enc6 = 6'h1C;
				4'h5: enc6 = 6'h19;
				4'h6: enc6 = 6'h1A;
				4'h7: enc6 = 6'h13;
				4'h8: enc6 = 6'h2C;
				4'h9: enc6 = 6'h25;
				4'hA: enc6 = 6'h26;
				4'hB: enc6 = 6'h23;
				4'hC: enc6 = 6'h34;
				4'hD: enc6 = 6'h31;
				4'hE: enc6 = 6'h32;
				default: enc6 = 6'h29;
			endcase
		end
	endfunction

	// returns {valid, nibble}
	function [4:0] dec6;
		input [5:0] sym;
		begin
			case (sym)
				6'h16: dec6 = 5'h10;
				6'h0D: dec6 = 5'h11;
				6'h0E: dec6 = 5'h12;
				6'h0B: dec6 = 5'h13;
				6'h1C: dec6 = 5'h14;
				6'h19: dec6 = 5'h15;
				6'h1A: dec6 = 5'h16;
				6'h13: dec6 = 5'h17;
				6'h2C: dec6 = 5'h18;
				6'h25: dec6 = 5'h19;
				6'h26: dec6 = 5'h1A;
				6'h23: dec6 = 5'h1B;
				6'h34: dec6 = 5'h1C;
				6'h31: dec6 = 5'h1D;
				6'h32: dec6 = 5'h1E;
				6'h29: dec6 = 5'h1F;
				default: dec6 = 5'h00;
			endcase
		end
	endfunction

	function [7:0] man_enc;
		input [3:0] nib;
		integer k;
		begin
			man_enc = 8'h00;
			for (k = 0; k < 4; k = k + 1)
				man_enc[2*k +: 2] = nib[k] ? 2'b01 : 2'b10;
		end
	endfunction

	assign page_hit = (SFR_PAGE_I == `MTSC_PAGE);
	assign ctl_wr = SFR_WR_I && page_hit && (SFR_ADDR_I == `MTSC_ADDR_CTL);
	assign active = dma_r && (enc_r || dec_r);
	assign reg_done = !dma_r && (enc_r || dec_r);
	assign dma_done = active && (st_r == ST_CALC);
	assign n_in = enc_r ? (mode_r ? 2'd2 : 2'd1) : (mode_r ? 2'd3 : 2'd2);
	assign n_out = enc_r ? (mode_r ? 2'd3 : 2'd2) : (mode_r ? 2'd2 : 2'd1);
	assign fifo_pop = active && (st_r == ST_FILL);
	assign DEC_ERR_O = error_r;

	// symbol translation of the current data word
	always @* begin
		man_byte = 8'h00;
		man_bad = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			man_byte[i] = data_r[2*i];
			if (data_r[2*i+1] == data_r[2*i])
				man_bad = 1'b1;
		end
		six_nib = 16'h0000;
		six_bad = 1'b0;
		dsym = 5'h00;
		for (i = 0; i < 4; i = i + 1) begin
			dsym = dec6(data_r[6*i +: 6]);
			six_nib[4*i +: 4] = dsym[3:0];
			if (!dsym[4])
				six_bad = 1'b1;
		end
		res = 24'h000000;
		res_err = 1'b0;
		if (enc_r) begin
			if (mode_r)
				res = {enc6(data_r[15:12]), enc6(data_r[11:8]),
					enc6(data_r[7:4]), enc6(data_r[3:0])};
			else
				res = {8'h00, man_enc(data_r[7:4]), man_enc(data_r[3:0])};
		end else if (mode_r) begin
			res_err = six_bad;
			res = six_bad ? {8'h00, `MTSC_ERR_FILL, `MTSC_ERR_FILL} : {8'h00, six_nib};
		end else begin
			res_err = man_bad;
			res = {16'h0000, man_bad ? `MTSC_ERR_FILL : man_byte};
		end
	end

	// byte positions inside the word for dma fill and drain
	always @* begin
		in_idx = endian_r ? n_in - 2'd1 - cnt_r : cnt_r;
		out_idx = endian_r ? n_out - 2'd1 - cnt_r : cnt_r;
		out_byte = data_r[{out_idx, 3'b000} +: 8];
	end

	always @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			data_r <= 24'h000000;
			ready_r <= 1'b0;
			error_r <= 1'b0;
			enc_r <= 1'b0;
			dec_r <= 1'b0;
			dma_r <= 1'b0;
			endian_r <= 1'b0;
			mode_r <= 1'b0;
			st_r <= ST_FILL;
			cnt_r <= 2'd0;
			DMA_OUT_VALID_O <= 1'b0;
			DMA_OUT_DATA_O <= `MTSC_RST_BYTE;
			SFR_RDATA_O <= `MTSC_RST_BYTE;
		end else begin
			// software writes to the data bytes
			if (SFR_WR_I && page_hit && SFR_ADDR_I == `MTSC_ADDR_LOW)
				data_r[7:0] <= SFR_WDATA_I;
			if (SFR_WR_I && page_hit && SFR_ADDR_I == `MTSC_ADDR_MID)
				data_r[15:8] <= SFR_WDATA_I;
			if (SFR_WR_I && page_hit && SFR_ADDR_I == `MTSC_ADDR_HIGH)
				data_r[23:16] <= SFR_WDATA_I;

			// flags: a write of zero clears, completion in the same cycle wins
			ready_r <= (ready_r && !(ctl_wr && !SFR_WDATA_I[`MTSC_BIT_READY]))
				|| reg_done || dma_done;
			error_r <= (error_r && !(ctl_wr && !SFR_WDATA_I[`MTSC_BIT_ERROR]))
				|| ((reg_done || dma_done) && res_err);

			if (reg_done) begin
				data_r <= res;
				enc_r <= 1'b0;
				dec_r <= 1'b0;
			end
			if (ctl_wr) begin
				enc_r <= SFR_WDATA_I[`MTSC_BIT_ENC];
				dec_r <= SFR_WDATA_I[`MTSC_BIT_DEC] && !SFR_WDATA_I[`MTSC_BIT_ENC];
				dma_r <= SFR_WDATA_I[`MTSC_BIT_DMA];
				endian_r <= SFR_WDATA_I[`MTSC_BIT_ENDIAN];
				mode_r <= SFR_WDATA_I[`MTSC_BIT_MODE];
			end

			// dma word loop: fill, translate, drain, repeat while started
			if (!active) begin
				st_r <= ST_FILL;
				cnt_r <= 2'd0;
				DMA_OUT_VALID_O <= 1'b0;
			end else begin
				case (st_r)
					ST_FILL: begin
						if (fifo_vld) begin
							data_r[{in_idx, 3'b000} +: 8] <= fifo_data;
							if (cnt_r == n_in - 2'd1) begin
								cnt_r <= 2'd0;
								st_r <= ST_CALC;
							end else begin
								cnt_r <= cnt_r + 2'd1;
							end
						end
					end
					ST_CALC: begin
						data_r <= res;
						st_r <= ST_DRAIN;
					end
					ST_DRAIN: begin
						if (!DMA_OUT_VALID_O || DMA_OUT_READY_I) begin
							if (cnt_r == n_out) begin
								DMA_OUT_VALID_O <= 1'b0;
								cnt_r <= 2'd0;
								st_r <= ST_FILL;
							end else begin
								DMA_OUT_VALID_O <= 1'b1;
								DMA_OUT_DATA_O <= out_byte;
								cnt_r <= cnt_r + 2'd1;
							end
						end
					end
					default: begin
						st_r <= ST_FILL;
						cnt_r <= 2'd0;
					end
				endcase
			end

			// registered read port
			if (SFR_RD_I && page_hit) begin
				case (SFR_ADDR_I)
					`MTSC_ADDR_LOW: SFR_RDATA_O <= data_r[7:0];
					`MTSC_ADDR_MID: SFR_RDATA_O <= data_r[15:8];
					`MTSC_ADDR_HIGH: SFR_RDATA_O <= data_r[23:16];
					`MTSC_ADDR_CTL: SFR_RDATA_O <= {ready_r, error_r, enc_r, dec_r,
						1'b0, dma_r, endian_r, mode_r};
					default: SFR_RDATA_O <= `MTSC_RST_BYTE;
				endcase
			end
		end
	end

	mtsc_fifo #(
		.WIDTH(8),
		.DEPTH(`MTSC_FIFO_DEPTH),
		.AW(2)
	) u_in_fifo (
		.clk_i(SYS_CLK_I),
		.rstn_i(RSTN_I),
		.in_valid_i(DMA_IN_VALID_I),
		.in_data_i(DMA_IN_DATA_I),
		.in_ready_o(DMA_IN_READY_O),
		.out_valid_o(fifo_vld),
		.out_data_o(fifo_data),
		.out_ready_i(fifo_pop)
	);
endmodule // mtsc_codec

// ---- tb/mtsc_properties.sv ----
// checker on the codec ports
`timescale 1ns/100ps
module mtsc_props (
	input wire SYS_CLK_I,
	input wire RSTN_I,
	input wire [7:0] SFR_PAGE_I,
	input wire [7:0] SFR_ADDR_I,
	input wire SFR_WR_I,
	input wire SFR_RD_I,
	input wire [7:0] SFR_WDATA_I,
	input wire [7:0] SFR_RDATA_O,
	input wire DMA_OUT_VALID_O,
	input wire [7:0] DMA_OUT_DATA_O,
	input wire DMA_OUT_READY_I,
	input wire DEC_ERR_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	wire pg = SFR_PAGE_I == 8'h02;
	wire wc = SFR_WR_I && pg && SFR_ADDR_I == 8'hC5;
	wire rc = SFR_RD_I && pg && SFR_ADDR_I == 8'hC5;
	wire cz = wc && SFR_WDATA_I == 8'h00;
	a_rd_unmapped: assert property (SFR_RD_I && pg && SFR_ADDR_I > 8'hC5 |=>
		SFR_RDATA_O == 8'h00) else $error("unmapped read");
	a_rd_foreign: assert property (SFR_RD_I && !pg |=> $stable(SFR_RDATA_O))
		else $error("foreign read");
	a_spare_bit: assert property (rc |=> !SFR_RDATA_O[3]) else $error("bit 3 set");
	a_err_sticky: assert property (DEC_ERR_O && !wc && !$past(wc) |=> DEC_ERR_O)
		else $error("error lost");
	a_err_clear: assert property (cz ##2 cz |=> !DEC_ERR_O) else $error("error kept");
	a_out_hold: assert property (DMA_OUT_VALID_O && !DMA_OUT_READY_I && !wc |=>
		DMA_OUT_VALID_O && $stable(DMA_OUT_DATA_O)) else $error("byte dropped");
	a_enc_done: assert property (wc && SFR_WDATA_I == 8'h21 ##2 rc |=>
		SFR_RDATA_O == 8'h81) else $error("encode status");
	a_dec_done: assert property (wc && SFR_WDATA_I == 8'h10 ##2 rc |=>
		SFR_RDATA_O[7] && SFR_RDATA_O[5:0] == 6'h00) else $error("decode status");
endmodule // mtsc_props

bind mtsc_codec mtsc_props u_props (.*);

// ---- tb/mtsc_dma_model.sv ----
// byte source and sink in place of the two dma channels
`timescale 1ns/100ps
module mtsc_dma_model (
	input wire clk_i,
	output logic in_valid_o,
	output logic [7:0] in_data_o,
	input wire in_ready_i,
	input wire out_valid_i,
	input wire [7:0] out_data_i,
	output logic out_ready_o
);
	logic [7:0] src_q [$];
	logic [7:0] snk_q [$];
	bit hold = 0;
	bit tk;
	// one process owns every output, reset values included
	initial begin
		{in_valid_o, in_data_o, out_ready_o} = 10'h000;
		forever begin
			@(posedge clk_i);
			tk = in_valid_o && in_ready_i;
			if (tk) void'(src_q.pop_front());
			if (out_valid_i && out_ready_o) snk_q.push_back(out_data_i);
			#1;
			if (tk || !in_valid_o) begin
				in_valid_o = src_q.size() != 0 && $urandom_range(3) != 0;
				in_data_o = in_valid_o ? src_q[0] : ~in_data_o;
			end
			out_ready_o = !hold && $urandom_range(3) != 0;
		end
	end
endmodule // mtsc_dma_model

// ---- tb/testbench.sv ----
// self-checking bench of the symbol codec
`timescale 1ns/100ps
module testbench;
	logic clk = 0, rstn = 0, wr = 0, rd = 0;
	logic [7:0] pg = 8'h02, ad = 8'h00, wd = 8'h00;
	wire [7:0] rdat, id, od;
	wire iv, ir, ov, orr, err;
	int bad_count = 0, cmp_count = 0, ni, no;
	logic m, k, e, fl;
	logic [7:0] o;
	logic [23:0] g, r, x, msk, ins, outs;
	logic [7:0] eq [$];
	logic [7:0] ops [6] = '{8'h26, 8'h27, 8'h16, 8'h17, 8'h24, 8'h15};
	// six-bit symbols, nibble 0 in the low bits
	localparam logic [95:0] T3 = 96'hA72C748E696C4DA65C2CE356;
	initial forever #5 clk = ~clk;
	mtsc_codec u_dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .SFR_PAGE_I(pg), .SFR_ADDR_I(ad),
		.SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wd), .SFR_RDATA_O(rdat),
		.DMA_IN_VALID_I(iv), .DMA_IN_DATA_I(id), .DMA_IN_READY_O(ir), .DMA_OUT_VALID_O(ov),
		.DMA_OUT_DATA_O(od), .DMA_OUT_READY_I(orr), .DEC_ERR_O(err));
	mtsc_dma_model u_dma (.clk_i(clk), .in_valid_o(iv), .in_data_o(id), .in_ready_i(ir),
		.out_valid_i(ov), .out_data_i(od), .out_ready_o(orr));
	function automatic [7:0] mn(input [3:0] n);
		for (int i = 0; i < 4; i++) mn[2*i+:2] = n[i] ? 2'b01 : 2'b10;
	endfunction
	function automatic [23:0] encode_start(input m, input [15:0] v);
		encode_start = m ? {T3[6*v[15:12]+:6], T3[6*v[11:8]+:6], T3[6*v[7:4]+:6], T3[6*v[3:0]+:6]}
			: {8'h00, mn(v[7:4]), mn(v[3:0])};
	endfunction
	task automatic chk(input logic [23:0] gv, ev);
		cmp_count++;
		if (gv !== ev) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, gv, ev);
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d);
		{wr, rd, ad, wd} = {w, !w, a, d};
		@(posedge clk) #1 {wr, rd} = 2'b00;
		@(posedge clk) #1;
	endtask
	task automatic rdw(output logic [23:0] v);
		acc(0, 8'hC4, 8'h00);
		v[23:16] = rdat;
		acc(0, 8'hC3, 8'h00);
		v[15:8] = rdat;
		acc(0, 8'hC2, 8'h00);
		v[7:0] = rdat;
	endtask
	task automatic regop(input logic [7:0] op, input logic [23:0] in, ex, input logic ef);
		acc(1, 8'hC5, 8'h00);
		acc(1, 8'hC5, 8'h00);
		acc(1, 8'hC4, in[23:16]);
		acc(1, 8'hC3, in[15:8]);
		acc(1, 8'hC2, in[7:0]);
		acc(1, 8'hC5, op);
		acc(0, 8'hC5, 8'h00);
		chk({16'h0, rdat}, {16'h0, 1'b1, ef, 5'h00, op[0]});
		chk({23'h0, err}, {23'h0, ef});
		rdw(g);
		chk(g, ex);
	endtask
	initial begin
		void'($urandom(97863));
		repeat (5) @(posedge clk);
		#1 rstn = 1;
		rdw(g);
		chk(g, 24'h0);
		chk({23'h0, ir}, 24'h1);
		acc(1, 8'hC5, 8'h08);
		acc(0, 8'hC5, 8'h00);
		chk({16'h0, rdat}, 24'h0);
		acc(1, 8'hC6, 8'h5A);
		acc(0, 8'hC6, 8'h00);
		chk({16'h0, rdat}, 24'h0);
		pg = 8'h01;
		acc(1, 8'hC2, 8'h77);
		acc(0, 8'hC5, 8'h00);
		pg = 8'h02;
		acc(0, 8'hC2, 8'h00);
		chk({16'h0, rdat}, 24'h0);
		$display("register map test done");
		for (int i = 0; i < 40; i++) begin
			r = 24'($urandom);
			m = i[0];
			k = i % 5 > 2;
			x = encode_start(m, r[15:0]);
			msk = m ? 24'hFFFF : 24'hFF;
			regop({7'h10, m}, r, x, 0);
			regop({7'h08, m}, k ? 24'h0 : x, k ? msk : r & msk, k);
		end
		// both start bits, flag bits and the spare bit written as one
		regop(8'hF9, r, encode_start(1, r[15:0]), 0);
		$display("register operation test done");
		foreach (ops[j]) begin
			o = ops[j];
			m = o[0];
			msk = m ? 24'hFFFF : 24'hFF;
			acc(1, 8'hC5, 8'h00);
			acc(1, 8'hC5, 8'h00);
			ni = m ? (o[4] ? 3 : 2) : (o[4] ? 2 : 1);
			no = m ? (o[4] ? 2 : 3) : (o[4] ? 1 : 2);
			eq.delete();
			e = 0;
			for (int w = 0; w < 6; w++) begin
				r = 24'($urandom);
				x = encode_start(m, r[15:0]);
				k = o[4] && w == 2;
				ins = o[4] ? (k ? 24'h0 : x) : r;
				outs = o[4] ? (k ? msk : r & msk) : x;
				e |= k;
				for (int b = 0; b < ni; b++) u_dma.src_q.push_back(ins[8*(o[1] ? ni-1-b : b)+:8]);
				for (int b = 0; b < no; b++) eq.push_back(outs[8*(o[1] ? no-1-b : b)+:8]);
			end
			u_dma.hold = 1;
			acc(1, 8'hC5, o);
			fl = 0;
			repeat (20) begin
				@(posedge clk);
				#1 fl |= !ir;
			end
			chk({23'h0, fl}, 24'h1);
			u_dma.hold = 0;
			for (int t = 0; t < 400 && u_dma.snk_q.size() < eq.size(); t++) @(posedge clk);
			#1;
			if (u_dma.snk_q.size() < eq.size()) begin
				bad_count++;
				final_report;
			end
			foreach (eq[b]) chk({16'h0, u_dma.snk_q[b]}, {16'h0, eq[b]});
			acc(0, 8'hC5, 8'h00);
			chk({16'h0, rdat}, {16'h0, 1'b1, e, o[5:0]});
			chk({23'h0, err}, {23'h0, e});
			u_dma.snk_q.delete();
		end
		$display("dma stream test done");
		final_report;
	end
endmodule // testbench
